// ### address_translation_packets_tb.sv
// testbench: requester and translator joined on link1; link2 feeds malformed requests to a second translator
// assumes: one request at a time; payload lookups answered by the bench
`timescale 1ns/1ps
module address_translation_packets_tb;
	import atp_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, req = 1'b0, xl_ack = 1'b0;
	logic rdy, pv, rok, wok, un, coh, done, rabt, xl_req, tabt, abt2, busy;
	logic [63:0] pay, p, e, xl_pay = 64'h0;
	logic [39:12] va = 28'h0, xl_va;
	logic [7:0] bus = 8'h00;
	logic [4:0] dev = 5'h00, unit = 5'h00, tag = 5'h00, rtag;
	logic [3:0] seq = 4'h0, nr = 4'h1, xl_idx;
	logic [2:0] func = 3'h0;
	logic [1:0] at;
	logic [5:0] rl;
	logic [63:0] allq[$], exq[$];
	logic [8:0] reqq[$], rspq[$], rsp2q[$];
	int failures = 0, tests_run = 0, ack_n, done_n, abt2_n, k, l, pv_n, ab1_n;
	atp_link_if link1();
	atp_link_if link2();
	atp_requester atp_requester_inst(.CLK_I(clk), .RSTN_I(rst_n), .LINK(link1), .REQ_I(req), .BUS_I(bus),
		.DEV_I(dev), .FUNC_I(func), .UNIT_I(unit), .TAG_I(tag), .SEQ_I(seq), .NRANGE_I(nr), .VADDR_I(va),
		.REQ_READY_O(rdy), .PAY_VALID_O(pv), .PAY_O(pay), .READ_OK_O(rok), .WRITE_OK_O(wok), .UNTRANS_O(un),
		.ATYPE_O(at), .COHERENT_O(coh), .REGION_LOG2_O(rl), .DONE_O(done), .ABORT_O(rabt), .RSP_TAG_O(rtag));
	atp_translator atp_translator_inst(.CLK_I(clk), .RSTN_I(rst_n), .LINK(link1), .XL_REQ_O(xl_req),
		.XL_VADDR_O(xl_va), .XL_IDX_O(xl_idx), .XL_ACK_I(xl_ack), .XL_PAY_I(xl_pay), .ABORT_O(tabt), .BUSY_O(busy));
	atp_translator atp_translator_inst2(.CLK_I(clk), .RSTN_I(rst_n), .LINK(link2), .XL_REQ_O(), .XL_VADDR_O(),
		.XL_IDX_O(), .XL_ACK_I(1'b0), .XL_PAY_I(64'h0), .ABORT_O(abt2), .BUSY_O());
	atp_link_sva atp_link_sva_inst(.CLK_I(clk), .RSTN_I(rst_n), .req_valid(link1.req_valid),
		.req_ctl(link1.req_ctl), .req_data(link1.req_data), .rsp_valid(link1.rsp_valid),
		.rsp_ctl(link1.rsp_ctl), .rsp_data(link1.rsp_data));
	// ----------------------------------------
	// checking and lookup model
	// ----------------------------------------
	task chk(input logic [63:0] s, input logic [63:0] x);
		tests_run++;
		if (s !== x) begin
			failures++;
			$display("Error %0t: seen %h expected %h", $time, s, x);
		end
	endtask
	task stop_test;
		if (failures == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		if (link1.req_valid === 1'b1) reqq.push_back({link1.req_ctl, link1.req_data});
		if (link1.rsp_valid === 1'b1) rspq.push_back({link1.rsp_ctl, link1.rsp_data});
		if (link2.rsp_valid === 1'b1) rsp2q.push_back({link2.rsp_ctl, link2.rsp_data});
	end
	// payloads end in a zero at a random bit 12..31, so every region size is reached
	always @(negedge clk) begin
		xl_ack <= 1'b0;
		if (xl_req === 1'b1 && !xl_ack) begin
			chk(xl_idx, ack_n);
			chk(xl_va, va);
			k = $urandom_range(31, 12);
			p = {$urandom, $urandom};
			for (int b = 12; b <= k; b++) p[b] = (b != k);
			allq.push_back(p);
			exq.push_back(p);
			xl_pay <= p;
			xl_ack <= 1'b1;
			ack_n++;
		end
		if (pv === 1'b1) begin
			e = exq.pop_front();
			l = 12;
			if (e[11]) begin
				l = 32;
				for (int b = 31; b >= 12; b--) if (!e[b]) l = b + 1;
			end
			chk(pay, e);
			chk(rok, e[0]);
			chk(wok, e[1]);
			chk(un, e[2]);
			chk(at, e[2] ? 2'h0 : 2'h1);
			chk(coh, e[10]);
			chk(rl, l);
		end
		if (done === 1'b1) done_n++;
		if (pv === 1'b1) pv_n++;
		if (tabt === 1'b1 || rabt === 1'b1) ab1_n++;
		if (abt2 === 1'b1) abt2_n++;
	end
	task automatic do_req(input int n);
		int t;
		for (t = 0; t < 100 && rdy !== 1'b1; t++) @(negedge clk);
		reqq.delete();
		rspq.delete();
		allq.delete();
		ack_n = 0;
		done_n = 0;
		pv_n = 0;
		ab1_n = 0;
		{bus, dev, func, unit, tag, seq} = 30'($urandom);
		va = 28'($urandom);
		nr = 4'(n);
		req = 1'b1;
		@(negedge clk);
		req = 1'b0;
		for (t = 0; t < 3000 && done_n == 0; t++) @(negedge clk);
		repeat (2) @(negedge clk);
		chk(done_n, 1);
		chk(rtag, tag);
		chk(pv_n, n);
		chk(ab1_n, 0);
		chk(busy, 1'b0);
		chk(reqq[0][7:0], {ATP_PFX_TOP, ATP_CMD_PREFIX});
		chk(reqq.size(), 12);
		chk(reqq[1][7:0], {dev, func});
		chk(reqq[2][7:0], bus);
		chk({reqq[4][7:6], reqq[5][6:5]}, seq);
		chk(reqq[5][4:0], unit);
		chk(reqq[6][5:0], {1'b0, tag});
		chk({reqq[7][1:0], reqq[6][7:6]}, 2 * n - 1);
		chk({reqq[11][7:0], reqq[10][7:0], reqq[9][7:0], reqq[8][7:4]}, va);
		for (t = 0; t < 12; t++) chk(reqq[t][8], t < 8);
		chk(rspq.size(), 4 + 8 * n);
		chk(rspq[1][4:0], unit);
		chk({rspq[3][5], rspq[3][1:0], rspq[2][7:5]}, (2 * n - 1) << 1);
		for (t = 0; t < 8 * n && rspq.size() == 4 + 8 * n; t++) chk(rspq[4 + t][7:0], allq[t / 8][8 * (t % 8) +: 8]);
	endtask
	task automatic bad_req(input int c);
		logic [7:0] b[12];
		int i;
		for (i = 0; i < 12; i++) b[i] = 8'($urandom);
		b[0] = {2'h2, ATP_CMD_PREFIX};
		b[3] = {6'h00, ATP_AT_TRANSLATE};
		b[4] = {2'h0, ATP_CMD_RDSZ};
		b[6][7:5] = 3'h2;
		b[7][1:0] = 2'h0;
		case (c)
			0: b[0][0] = 1'b1;
			1: b[3][1:0] = ATP_AT_UNTRANSLATED;
			2: b[4][5] = 1'b1;
			3: b[6][5] = 1'b1;
			default: b[6][6] = 1'b0;
		endcase
		rsp2q.delete();
		abt2_n = 0;
		for (i = 0; i < 12; i++) begin
			@(negedge clk);
			link2.req_valid = 1'b1;
			link2.req_ctl = (i < 8);
			link2.req_data = b[i];
		end
		@(negedge clk);
		link2.req_valid = 1'b0;
		link2.req_ctl = 1'b0;
		link2.req_data = ~b[11];
		repeat (40) @(negedge clk);
		chk(abt2_n, 1);
		chk(rsp2q.size(), 4);
		chk({rsp2q[3][5], rsp2q[2][5], rsp2q[3][1:0], rsp2q[2][7:6]}, 6'h30);
	endtask
	initial begin
		link2.req_valid = 1'b0;
		link2.req_ctl = 1'b0;
		link2.req_data = 8'h00;
		void'($urandom(32'h1BE2));
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		for (int n = 1; n <= 8; n++) do_req(n);
		for (int n = 0; n < 3; n++) do_req($urandom_range(8, 1));
		for (int c = 0; c < 5; c++) bad_req(c);
		stop_test;
	end
	initial begin
		#2000000;
		failures++;
		stop_test;
	end
endmodule

// ### atp_link_if.sv
// interface: one byte-wide packet stream in each direction between requester and translator
// assumes: single clock; ctl marks control bit-times, valid marks any bit-time
`timescale 1ns/1ps
interface atp_link_if;
	logic req_valid;
	logic req_ctl;
	logic [7:0] req_data;
	logic rsp_valid;
	logic rsp_ctl;
	logic [7:0] rsp_data;
	modport requester (output req_valid, output req_ctl, output req_data,
		input rsp_valid, input rsp_ctl, input rsp_data);
	modport translator (input req_valid, input req_ctl, input req_data,
		output rsp_valid, output rsp_ctl, output rsp_data);
endinterface

// ### atp_link_sva.sv
// checker: framing and field rules on the request and response streams of one link
// assumes: both ends on CLK_I, one request outstanding at a time
`timescale 1ns/1ps
module atp_link_sva
	import atp_pkg::*;
(
	// clock and reset
	input wire logic CLK_I,
	input wire logic RSTN_I,
	// link signals
	input wire logic req_valid,
	input wire logic req_ctl,
	input wire logic [7:0] req_data,
	input wire logic rsp_valid,
	input wire logic rsp_ctl,
	input wire logic [7:0] rsp_data
);
	import atp_pkg::*;
	localparam int MAXB = ATP_RSP_HDR_BT + ATP_MAX_PAY * ATP_PAY_BYTES;
	logic [3:0] rc_q;
	logic [6:0] sc_q;
	logic [4:0] tag_q;
	logic [4:0] unit_q;
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);
	// ----------------------------------------
	// bit-time counters
	// ----------------------------------------
	// response count restarts per request and saturates, so a runaway response stays visible
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rc_q <= 4'h0;
			sc_q <= 7'h00;
			tag_q <= 5'h00;
			unit_q <= 5'h00;
		end else begin
			if (req_valid) rc_q <= (rc_q == 4'hB) ? 4'h0 : rc_q + 4'h1;
			if (req_valid && rc_q == 4'h5) unit_q <= req_data[4:0];
			if (req_valid && rc_q == 4'h6) tag_q <= req_data[4:0];
			if (req_valid && rc_q == 4'h0) sc_q <= 7'h00;
			else if (rsp_valid && sc_q != 7'h7F) sc_q <= sc_q + 7'h01;
		end
	end
	property p_req_prefix; req_valid && rc_q == 4'h0 |-> req_data[5:0] == ATP_CMD_PREFIX; endproperty
	a_req_prefix: assert property (p_req_prefix) else $error("bad prefix command");
	property p_req_at; req_valid && rc_q == 4'h3 |-> req_data[1:0] == ATP_AT_TRANSLATE; endproperty
	a_req_at: assert property (p_req_at) else $error("bad address type");
	property p_req_cmd; req_valid && rc_q == 4'h4 |-> (req_data[5:0] & ATP_CMD_RDSZ_MASK) == ATP_CMD_RDSZ_VAL; endproperty
	a_req_cmd: assert property (p_req_cmd) else $error("bad read command");
	property p_req_cnt; req_valid && rc_q == 4'h6 |-> !req_data[5] && req_data[6]; endproperty
	a_req_cnt: assert property (p_req_cnt) else $error("bad compat or count");
	property p_req_frame;
		req_valid && rc_q == 4'h0 |-> (req_valid && req_ctl)[*8] ##1 (req_valid && !req_ctl)[*4];
	endproperty
	a_req_frame: assert property (p_req_frame) else $error("bad request framing");
	// header leaves the translator's flops two cycles after the last request bit-time
	property p_rsp_start; req_valid && rc_q == 4'hB |-> ##2 rsp_valid && rsp_data[5:0] == ATP_CMD_RDRSP; endproperty
	a_rsp_start: assert property (p_rsp_start) else $error("response not started");
	property p_rsp_cnt; rsp_valid && sc_q == 7'h02 |-> rsp_data[6] && !rsp_data[5]; endproperty
	a_rsp_cnt: assert property (p_rsp_cnt) else $error("bad response count");
	property p_rsp_ctl; rsp_valid |-> rsp_ctl == (sc_q < 7'h04); endproperty
	a_rsp_ctl: assert property (p_rsp_ctl) else $error("bad response ctl");
	property p_rsp_max; rsp_valid |-> sc_q < 7'(MAXB); endproperty
	a_rsp_max: assert property (p_rsp_max) else $error("too many payloads");
	property p_rsp_echo;
		rsp_valid && sc_q == 7'h01 |-> rsp_data[4:0] == unit_q ##1 rsp_valid && rsp_data[4:0] == tag_q;
	endproperty
	a_rsp_echo: assert property (p_rsp_echo) else $error("unit or tag not echoed");
	c_one: cover property (rsp_valid && sc_q == 7'h0B);
	c_full: cover property (rsp_valid && sc_q == 7'(MAXB - 1));
	c_req: cover property (req_valid && rc_q == 4'hB);
endmodule

// ### atp_pkg.sv
// package: packet field codes and sizes shared by both ends of the translation link
// assumes: both ends run on one clock, CLK_I, at 20 MHz
package atp_pkg;
	localparam int ATP_BT_W = 8;
	localparam logic [5:0] ATP_CMD_PREFIX = 6'h3E;
	localparam logic [1:0] ATP_PFX_TOP = 2'h2;
	localparam logic [1:0] ATP_AT_TRANSLATE = 2'h1;
	localparam logic [1:0] ATP_AT_UNTRANSLATED = 2'h0;
	localparam logic [5:0] ATP_CMD_RDSZ_MASK = 6'h35;
	localparam logic [5:0] ATP_CMD_RDSZ_VAL = 6'h14;
	localparam logic [5:0] ATP_CMD_RDRSP = 6'h30;
	localparam logic [5:0] ATP_CMD_RDSZ = 6'h14;
	localparam int ATP_REQ_BT = 12;
	localparam int ATP_RSP_HDR_BT = 4;
	localparam int ATP_PAY_BYTES = 8;
	localparam int ATP_MAX_PAY = 8;
	localparam int ATP_PAGE_SHIFT = 12;
	localparam int ATP_SIZE_TOP = 31;
	localparam int ATP_R_BIT = 0;
	localparam int ATP_W_BIT = 1;
	localparam int ATP_U_BIT = 2;
	localparam int ATP_COH_BIT = 10;
	localparam int ATP_SIZE_BIT = 11;
	localparam logic [5:0] ATP_SIZE_4K = 6'h0C;

	typedef logic [ATP_BT_W-1:0] atp_bt_t;

	// count field encodes 2N-1 dwords; legal values are odd
	function automatic logic atp_count_ok(input logic [3:0] cnt);
		return cnt[0];
	endfunction

	// log2 of region bytes: one above the lowest zero bit in bits 12..31, 32 if none, when size flag set, else 12
	function automatic logic [5:0] atp_region_log2(input logic [63:0] pay);
		logic [5:0] r;
		r = ATP_SIZE_4K;
		if (pay[ATP_SIZE_BIT]) begin
			r = 6'(ATP_SIZE_TOP + 1);
			for (int b = ATP_SIZE_TOP; b >= ATP_PAGE_SHIFT; b--) begin
				if (!pay[b]) begin
					r = 6'(b + 1);
				end
			end
		end
		return r;
	endfunction
endpackage

// ### atp_requester.sv
// requester end: sends translation requests and unpacks the response payloads
// assumes: translator answers each request before the next is started
`timescale 1ns/1ps
module atp_requester
	import atp_pkg::*;
(
	// clock and reset
	input wire logic CLK_I,
	input wire logic RSTN_I,
	// link
	atp_link_if.requester LINK,
	// request from user
	input wire logic REQ_I,
	input wire logic [7:0] BUS_I,
	input wire logic [4:0] DEV_I,
	input wire logic [2:0] FUNC_I,
	input wire logic [4:0] UNIT_I,
	input wire logic [4:0] TAG_I,
	input wire logic [3:0] SEQ_I,
	input wire logic [3:0] NRANGE_I,
	input wire logic [39:12] VADDR_I,
	output logic REQ_READY_O,
	// translations back to user
	output logic PAY_VALID_O,
	output logic [63:0] PAY_O,
	output logic READ_OK_O,
	output logic WRITE_OK_O,
	output logic UNTRANS_O,
	output logic [1:0] ATYPE_O,
	output logic COHERENT_O,
	output logic [5:0] REGION_LOG2_O,
	output logic DONE_O,
	output logic ABORT_O,
	output logic [4:0] RSP_TAG_O
);
	import atp_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum {R_IDLE, R_TX, R_WAIT} atp_rstate_e;

	typedef struct packed {
		atp_rstate_e st;
		logic [3:0] bt;
		logic [7:0] bus;
		logic [4:0] dev;
		logic [2:0] func;
		logic [4:0] unit;
		logic [4:0] tag;
		logic [3:0] seq;
		logic [3:0] cnt;
		logic [39:12] va;
		logic [3:0] want;
		logic [3:0] rbt;
		logic [1:0] rcnt_lo;
		logic err;
		logic [3:0] got;
		logic [3:0] total;
		logic [2:0] byt;
		logic [63:0] pay;
		logic pay_valid;
		logic done;
		logic abort;
		logic [4:0] rtag;
	} atp_rstate_s;

	atp_rstate_s s_q, s_d;
	atp_bt_t tx;

	// ----------------------------------------------------------------
	// request bit-times
	// ----------------------------------------------------------------
	always_comb begin
		unique case (s_q.bt)
			4'h0: tx = {ATP_PFX_TOP, ATP_CMD_PREFIX};
			4'h1: tx = {s_q.dev, s_q.func};
			4'h2: tx = s_q.bus;
			4'h3: tx = {6'h00, ATP_AT_TRANSLATE};
			4'h4: tx = {s_q.seq[3:2], ATP_CMD_RDSZ};
			4'h5: tx = {1'b0, s_q.seq[1:0], s_q.unit};
			4'h6: tx = {s_q.cnt[1:0], 1'b0, s_q.tag};
			4'h7: tx = {6'h00, s_q.cnt[3:2]};
			4'h8: tx = {s_q.va[15:12], 4'h0};
			4'h9: tx = s_q.va[23:16];
			4'hA: tx = s_q.va[31:24];
			default: tx = s_q.va[39:32];
		endcase
	end

	always_comb begin
		logic [3:0] tot;
		tot = 4'h0;
		s_d = s_q;
		s_d.pay_valid = 1'b0;
		s_d.done = 1'b0;
		s_d.abort = 1'b0;
		unique case (s_q.st)
			R_IDLE: begin
				if (REQ_I) begin
					s_d.st = R_TX;
					s_d.bt = 4'h0;
					s_d.bus = BUS_I;
					s_d.dev = DEV_I;
					s_d.func = FUNC_I;
					s_d.unit = UNIT_I;
					s_d.tag = TAG_I;
					s_d.seq = SEQ_I;
					s_d.want = NRANGE_I;
					s_d.cnt = 4'(2 * NRANGE_I - 1);
					s_d.va = VADDR_I;
				end
			end
			R_TX: begin
				s_d.bt = s_q.bt + 4'h1;
				if (s_q.bt == 4'(ATP_REQ_BT - 1)) begin
					s_d.st = R_WAIT;
					s_d.rbt = 4'h0;
					s_d.got = 4'h0;
					s_d.byt = 3'h0;
				end
			end
			R_WAIT: begin
				if (LINK.rsp_valid && LINK.rsp_ctl) begin
					s_d.rbt = s_q.rbt + 4'h1;
					if (s_q.rbt == 4'h2) begin
						s_d.rcnt_lo = LINK.rsp_data[7:6];
						s_d.err = LINK.rsp_data[5];
						s_d.rtag = LINK.rsp_data[4:0];
					end
					if (s_q.rbt == 4'(ATP_RSP_HDR_BT - 1)) begin
						tot = 4'(({LINK.rsp_data[1:0], s_q.rcnt_lo} + 5'h1) >> 1);
						// payloads past a nonzero requested count are never delivered
						s_d.total = (tot > s_q.want) ? s_q.want : tot;
						if (s_q.err || LINK.rsp_data[5]) begin
							s_d.abort = 1'b1;
							s_d.st = R_IDLE;
						end
					end
				end else if (LINK.rsp_valid) begin
					s_d.pay[8*s_q.byt +: 8] = LINK.rsp_data;
					s_d.byt = s_q.byt + 3'h1;
					if (s_q.byt == 3'(ATP_PAY_BYTES - 1)) begin
						s_d.pay_valid = 1'b1;
						s_d.got = s_q.got + 4'h1;
						if (s_q.got + 4'h1 >= s_q.total) begin
							s_d.done = 1'b1;
							s_d.st = R_IDLE;
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			s_q <= '{st: R_IDLE, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign LINK.req_valid = (s_q.st == R_TX);
	// address bit-times carry no control marking
	assign LINK.req_ctl = (s_q.st == R_TX) && (s_q.bt < 4'h8);
	assign LINK.req_data = (s_q.st == R_TX) ? tx : 8'h00;
	assign REQ_READY_O = (s_q.st == R_IDLE);
	assign PAY_VALID_O = s_q.pay_valid;
	assign PAY_O = s_q.pay;
	assign READ_OK_O = s_q.pay[ATP_R_BIT];
	assign WRITE_OK_O = s_q.pay[ATP_W_BIT];
	assign UNTRANS_O = s_q.pay[ATP_U_BIT];
	assign ATYPE_O = s_q.pay[ATP_U_BIT] ? ATP_AT_UNTRANSLATED : ATP_AT_TRANSLATE;
	assign COHERENT_O = s_q.pay[ATP_COH_BIT];
	assign REGION_LOG2_O = atp_region_log2(s_q.pay);
	assign DONE_O = s_q.done;
	assign ABORT_O = s_q.abort;
	assign RSP_TAG_O = s_q.rtag;
endmodule

// ### atp_translator.sv
// translator end: parses translation requests and returns read responses with payloads
// assumes: requests arrive as twelve back-to-back bit-times; translations come from a user port
`timescale 1ns/1ps
module atp_translator
	import atp_pkg::*;
#(
	parameter int MAX_PAY = atp_pkg::ATP_MAX_PAY
) (
	// clock and reset
	input wire logic CLK_I,
	input wire logic RSTN_I,
	// link
	atp_link_if.translator LINK,
	// lookup request towards user
	output logic XL_REQ_O,
	output logic [39:12] XL_VADDR_O,
	output logic [3:0] XL_IDX_O,
	// lookup answer from user
	input wire logic XL_ACK_I,
	input wire logic [63:0] XL_PAY_I,
	// status
	output logic ABORT_O,
	output logic BUSY_O
);
	import atp_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum {S_RX, S_LOOK, S_HDR, S_PAY} atp_tstate_e;

	typedef struct packed {
		atp_tstate_e st;
		logic [3:0] bt;
		logic [5:0] pcmd;
		logic [1:0] atype;
		logic [5:0] cmd;
		logic [4:0] unit;
		logic [4:0] tag;
		logic [3:0] cnt;
		logic compat;
		logic [39:12] va;
		logic bad;
		logic [3:0] npay;
		logic [3:0] pidx;
		logic [2:0] byt;
		logic [63:0] pay;
		logic rsp_valid;
		logic rsp_ctl;
		atp_bt_t rsp_data;
		logic xl_req;
		logic abort;
	} atp_tstate_s;

	atp_tstate_s s_q, s_d;

	// ----------------------------------------------------------------
	// response count field
	// ----------------------------------------------------------------
	// 2N-1 dwords for N payloads; an aborted answer carries none
	function automatic logic [3:0] rsp_count(input logic bad, input logic [3:0] npay);
		logic [3:0] c;
		if (bad) begin
			c = 4'h0;
		end else begin
			c = 4'(2 * npay - 1);
		end
		return c;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [4:0] n;
		logic [3:0] rc;
		n = 5'h0;
		rc = rsp_count(s_q.bad, s_q.npay);
		s_d = s_q;
		s_d.rsp_valid = 1'b0;
		s_d.rsp_ctl = 1'b0;
		s_d.rsp_data = 8'h00;
		s_d.abort = 1'b0;
		unique case (s_q.st)
			S_RX: begin
				if (LINK.req_valid) begin
					unique case (s_q.bt)
						4'h0: s_d.pcmd = LINK.req_data[5:0];
						4'h3: s_d.atype = LINK.req_data[1:0];
						4'h4: s_d.cmd = LINK.req_data[5:0];
						4'h5: s_d.unit = LINK.req_data[4:0];
						4'h6: begin
							s_d.cnt[1:0] = LINK.req_data[7:6];
							s_d.compat = LINK.req_data[5];
							s_d.tag = LINK.req_data[4:0];
						end
						4'h7: s_d.cnt[3:2] = LINK.req_data[1:0];
						4'h8: s_d.va[15:12] = LINK.req_data[7:4];
						4'h9: s_d.va[23:16] = LINK.req_data;
						4'hA: s_d.va[31:24] = LINK.req_data;
						4'hB: s_d.va[39:32] = LINK.req_data;
						default: ;
					endcase
					s_d.bt = s_q.bt + 4'h1;
					// malformed if control marking is wrong for the position
					if (!LINK.req_ctl && s_q.bt < 4'h8) s_d.bad = 1'b1;
					// address bit-times marked as control are refused too
					if (LINK.req_ctl && s_q.bt >= 4'h8) s_d.bad = 1'b1;
					if (s_q.bt == 4'(ATP_REQ_BT - 1)) begin
						s_d.bt = 4'h0;
						s_d.st = S_HDR;
						s_d.pidx = 4'h0;
						s_d.byt = 3'h0;
					end
				end
			end
			S_HDR: begin
				if (s_q.bt == 4'h0) begin
					// decide once, on entry
					if (s_q.bad || s_q.pcmd != ATP_CMD_PREFIX || s_q.atype != ATP_AT_TRANSLATE
						|| (s_q.cmd & ATP_CMD_RDSZ_MASK) != ATP_CMD_RDSZ_VAL || s_q.compat
						|| !atp_count_ok(s_q.cnt)) begin
						s_d.bad = 1'b1;
					end
					n = 5'({1'b0, s_q.cnt} + 5'h1) >> 1;
					s_d.npay = (n > 5'(MAX_PAY)) ? 4'(MAX_PAY) : n[3:0];
				end
				s_d.rsp_valid = 1'b1;
				s_d.rsp_ctl = 1'b1;
				unique case (s_q.bt)
					4'h0: s_d.rsp_data = {2'b00, ATP_CMD_RDRSP};
					4'h1: s_d.rsp_data = {3'b000, s_q.unit};
					4'h2: s_d.rsp_data = {rc[1:0], s_q.bad, s_q.tag};
					default: s_d.rsp_data = {2'b00, s_q.bad, 3'b000, rc[3:2]};
				endcase
				s_d.bt = s_q.bt + 4'h1;
				if (s_q.bt == 4'(ATP_RSP_HDR_BT - 1)) begin
					s_d.bt = 4'h0;
					s_d.abort = s_q.bad;
					s_d.st = s_q.bad ? S_RX : S_LOOK;
					s_d.xl_req = !s_q.bad;
					if (s_q.bad) s_d.bad = 1'b0;
				end
			end
			S_LOOK: begin
				if (XL_ACK_I) begin
					s_d.xl_req = 1'b0;
					s_d.pay = XL_PAY_I;
					s_d.st = S_PAY;
					s_d.byt = 3'h0;
				end
			end
			S_PAY: begin
				s_d.rsp_valid = 1'b1;
				s_d.rsp_data = s_q.pay[8*s_q.byt +: 8];
				s_d.byt = s_q.byt + 3'h1;
				if (s_q.byt == 3'(ATP_PAY_BYTES - 1)) begin
					s_d.pidx = s_q.pidx + 4'h1;
					if (s_q.pidx + 4'h1 == s_q.npay) begin
						s_d.st = S_RX;
					end else begin
						s_d.st = S_LOOK;
						s_d.xl_req = 1'b1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			s_q <= '{st: S_RX, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign LINK.rsp_valid = s_q.rsp_valid;
	assign LINK.rsp_ctl = s_q.rsp_ctl;
	assign LINK.rsp_data = s_q.rsp_data;
	assign XL_REQ_O = s_q.xl_req;
	// consecutive ranges: one page per index, the user may scale
	assign XL_VADDR_O = s_q.va;
	assign XL_IDX_O = s_q.pidx;
	assign ABORT_O = s_q.abort;
	assign BUSY_O = (s_q.st != S_RX) || (s_q.bt != 4'h0);
endmodule
